// ===== core/fop_ctrl.sv
// Flash option loader and access protection, with an APB register port.
// Assumes requests, debug and boot indications come from logic on pclk.
// Notes on behaviour
// - One lock bit covers two pages.
// - Read protection follows only reset-loaded code.
// - Protected array reads only from user code.
// - Debug SRAM load and run stay allowed.
// - Unlocking code first triggers a mass erase.
// - Erased code 0xFF still means protected.
// - Code in bits 7:0; 0xA5 open.
// - Locked page program or erase flags violation.
// - Lock bits act after next reset load.
// - Pages 0 to 3 always locked.
// - Debug or SRAM boot: only mass erase and option program.
// - Unlock: erase options, reprogram, reset.
// - Bad complement half loads the default.
// - Load words from fixed information addresses.
// - Bit 10 permits watchdog disable.
// - Bit 9 picks deep idle watchdog action.
// - Bit 8 picks light idle watchdog action.
// - Lock bit zero protects its pair.
// - Sixteen bits per word, lowest pair first.
// - Locked target aborts and sets flag.
`timescale 1ns/1ps
module fop_ctrl
  import fop_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             fl_rd_req,
  output logic      [17:0] fl_rd_addr,
  input  wire logic        fl_rd_valid,
  input  wire logic [31:0] fl_rd_data,
  input  wire logic        acc_valid,
  input  wire logic [2:0]  acc_kind,
  input  wire logic [17:0] acc_addr,
  input  wire logic [31:0] acc_wdata,
  input  wire logic        acc_sram,
  input  wire logic        acc_from_user,
  input  wire logic        acc_debug,
  input  wire logic        acc_boot_sram,
  output logic             acc_grant,
  output logic             acc_refuse,
  output logic             op_go,
  output logic      [2:0]  op_kind,
  output logic      [17:0] op_addr,
  output logic      [31:0] op_wdata,
  output logic             read_protect_active,
  output logic             watchdog_disable_permit,
  output logic             deep_idle_watchdog_action,
  output logic             light_idle_watchdog_action,
  output logic             load_done
);

  typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} fop_ld_t;

  fop_ld_t      ld_state_q, ld_state_d;
  logic [3:0]   ld_idx_q, ld_idx_d;
  logic         fl_rd_req_q, fl_rd_req_d;
  logic [17:0]  fl_rd_addr_q, fl_rd_addr_d;
  logic [15:0]  sys_opt_q, sys_opt_d;
  logic [127:0] page_pair_write_lock_bits_q, page_pair_write_lock_bits_d;
  logic [15:0]  chk_dflt;
  logic [15:0]  chk_value;
  logic         chk_valid;
  logic [3:0]   idx_m1;
  logic         rdp_active;

  logic         grant_q, grant_d;
  logic         refuse_q, refuse_d;
  logic         op_go_q, op_go_d;
  logic [2:0]   op_kind_q, op_kind_d;
  logic [17:0]  op_addr_q, op_addr_d;
  logic [31:0]  op_wdata_q, op_wdata_d;
  logic         pend_q, pend_d;
  logic [17:0]  pend_addr_q, pend_addr_d;
  logic [31:0]  pend_wdata_q, pend_wdata_d;
  logic         viol_q, viol_d;
  logic         viol_set;
  logic         viol_clr;
  logic         page_locked;
  logic         main_array;

  logic         ctrl_q, ctrl_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         apb_setup;
  logic         apb_write;

  fop_opt_check u_check (
    .word  (fl_rd_data),
    .dflt  (chk_dflt),
    .value (chk_value),
    .valid (chk_valid)
  );

  fop_page_lock u_lock (
    .lock_bits (page_pair_write_lock_bits_q),
    .page      (acc_addr[PAGE_MSB:PAGE_LSB]),
    .lock_all  (ctrl_q),
    .locked    (page_locked)
  );

  assign rdp_active = (sys_opt_q[7:0] != RDP_OPEN);
  assign idx_m1     = ld_idx_q - 4'h1;
  assign main_array = ~acc_addr[NVR_BIT];

  // Option loader: reads the system word, then the eight lock words from the top down.
  always_comb begin
    ld_state_d                  = ld_state_q;
    ld_idx_d                    = ld_idx_q;
    fl_rd_req_d                 = 1'b0;
    fl_rd_addr_d                = fl_rd_addr_q;
    sys_opt_d                   = sys_opt_q;
    page_pair_write_lock_bits_d = page_pair_write_lock_bits_q;
    chk_dflt                    = (ld_idx_q == 4'h0) ? SYS_DEFAULT : LOCK_DEFAULT;
    case (ld_state_q)
      LD_REQ: begin
        fl_rd_req_d  = 1'b1;
        fl_rd_addr_d = (ld_idx_q == 4'h0) ? SYS_OPT_ADDR : LOCK_OPT_TOP - {12'h000, idx_m1, 2'b00};
        ld_state_d   = LD_WAIT;
      end
      LD_WAIT: begin
        if (fl_rd_valid) begin
          // word k covers pages 32k up
          if (ld_idx_q == 4'h0) begin
            sys_opt_d = chk_value;
          end else begin
            page_pair_write_lock_bits_d[idx_m1[2:0]*OPT_HALF +: OPT_HALF] = chk_value;
          end
          ld_idx_d   = ld_idx_q + 4'h1;
          ld_state_d = (ld_idx_q == LOAD_LAST_IDX) ? LD_DONE : LD_REQ;
        end
      end
      LD_DONE: begin
        ld_state_d = LD_DONE;
      end
      default: begin
        ld_state_d = LD_REQ;
      end
    endcase
  end

  // Loader registers; the reset state is the safe default until real values arrive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state_q                  <= LD_REQ;
      ld_idx_q                    <= 4'h0;
      fl_rd_req_q                 <= 1'b0;
      fl_rd_addr_q                <= 18'h00000;
      sys_opt_q                   <= SYS_DEFAULT;
      page_pair_write_lock_bits_q <= {LOCK_WORDS{LOCK_DEFAULT}};
    end else begin
      ld_state_q                  <= ld_state_d;
      ld_idx_q                    <= ld_idx_d;
      fl_rd_req_q                 <= fl_rd_req_d;
      fl_rd_addr_q                <= fl_rd_addr_d;
      sys_opt_q                   <= sys_opt_d;
      page_pair_write_lock_bits_q <= page_pair_write_lock_bits_d;
    end
  end

  // Access checker: answers every request one cycle later with grant or refuse.
  always_comb begin
    grant_d      = 1'b0;
    refuse_d     = 1'b0;
    viol_set     = 1'b0;
    op_go_d      = 1'b0;
    op_kind_d    = op_kind_q;
    op_addr_d    = op_addr_q;
    op_wdata_d   = op_wdata_q;
    pend_d       = pend_q;
    pend_addr_d  = pend_addr_q;
    pend_wdata_d = pend_wdata_q;
    if (pend_q) begin
      op_go_d    = 1'b1;
      op_kind_d  = ACC_OPT_PROG;
      op_addr_d  = pend_addr_q;
      op_wdata_d = pend_wdata_q;
      pend_d     = 1'b0;
      refuse_d   = acc_valid;
    end else if (acc_valid) begin
      if (ld_state_q != LD_DONE) begin
        refuse_d = 1'b1;
      end else begin
        case (acc_kind)
          ACC_READ: begin
            if (acc_sram || !main_array || !rdp_active || acc_from_user) begin
              grant_d = 1'b1;
            end else begin
              refuse_d = 1'b1;
            end
          end
          ACC_PROG, ACC_PAGE_ERS: begin
            if (acc_sram) begin
              grant_d = 1'b1;
            end else if (acc_debug || acc_boot_sram) begin
              refuse_d = 1'b1;
            end else if (main_array && page_locked) begin
              refuse_d = 1'b1;
              viol_set = 1'b1;
            end else begin
              grant_d    = 1'b1;
              op_go_d    = 1'b1;
              op_kind_d  = acc_kind;
              op_addr_d  = acc_addr;
              op_wdata_d = acc_wdata;
            end
          end
          ACC_MASS_ERS: begin
            grant_d    = 1'b1;
            op_go_d    = 1'b1;
            op_kind_d  = ACC_MASS_ERS;
            op_addr_d  = acc_addr;
            op_wdata_d = acc_wdata;
          end
          ACC_OPT_PROG: begin
            grant_d    = 1'b1;
            op_go_d    = 1'b1;
            op_addr_d  = acc_addr;
            op_wdata_d = acc_wdata;
            if (acc_addr == SYS_OPT_ADDR && acc_wdata[7:0] == RDP_OPEN && rdp_active) begin
              op_kind_d    = ACC_MASS_ERS;
              pend_d       = 1'b1;
              pend_addr_d  = acc_addr;
              pend_wdata_d = acc_wdata;
            end else begin
              op_kind_d = ACC_OPT_PROG;
            end
          end
          default: begin
            refuse_d = 1'b1;
          end
        endcase
      end
    end
    viol_d = viol_set | (viol_q & ~viol_clr);
  end

  // Access registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_q      <= 1'b0;
      refuse_q     <= 1'b0;
      op_go_q      <= 1'b0;
      op_kind_q    <= ACC_READ;
      op_addr_q    <= 18'h00000;
      op_wdata_q   <= 32'h00000000;
      pend_q       <= 1'b0;
      pend_addr_q  <= 18'h00000;
      pend_wdata_q <= 32'h00000000;
      viol_q       <= 1'b0;
    end else begin
      grant_q      <= grant_d;
      refuse_q     <= refuse_d;
      op_go_q      <= op_go_d;
      op_kind_q    <= op_kind_d;
      op_addr_q    <= op_addr_d;
      op_wdata_q   <= op_wdata_d;
      pend_q       <= pend_d;
      pend_addr_q  <= pend_addr_d;
      pend_wdata_q <= pend_wdata_d;
      viol_q       <= viol_d;
    end
  end

  // APB slave with no wait states; read data is registered in the setup phase, so it can come straight from a flop.
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready_q & pwrite;
  assign viol_clr  = apb_write && paddr == REG_STATUS && pstrb[0] && pwdata[ST_VIOL];

  always_comb begin
    pready_d  = apb_setup;
    pslverr_d = 1'b0;
    prdata_d  = 32'h00000000;
    ctrl_d    = ctrl_q;
    if (apb_setup) begin
      if (paddr == REG_STATUS) begin
        prdata_d[ST_VIOL]  = viol_q;
        prdata_d[ST_RDP]   = rdp_active;
        prdata_d[ST_DONE]  = (ld_state_q == LD_DONE);
        prdata_d[ST_WD_LO +: 3] = sys_opt_q[WD_LIGHT_BIT +: 3];
      end else if (paddr == REG_SYS_OPT) begin
        prdata_d[15:0] = sys_opt_q;
      end else if (paddr == REG_CTRL) begin
        prdata_d[CTRL_LOCK_ALL] = ctrl_q;
      end else if (paddr[11:5] == REG_LOCK_BASE[11:5] && paddr[1:0] == 2'b00) begin
        prdata_d[15:0] = page_pair_write_lock_bits_q[paddr[4:2]*OPT_HALF +: OPT_HALF];
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // Locking everything is one-way until reset so runaway code cannot undo it.
    if (apb_write && paddr == REG_CTRL && pstrb[0] && pwdata[CTRL_LOCK_ALL]) begin
      ctrl_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      ctrl_q    <= CTRL_RESET;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      ctrl_q    <= ctrl_d;
    end
  end

  // Outputs straight from flops, except read_protect_active and load_done, which are decoded from flops.
  assign prdata                     = prdata_q;
  assign pready                     = pready_q;
  assign pslverr                    = pslverr_q;
  assign fl_rd_req                  = fl_rd_req_q;
  assign fl_rd_addr                 = fl_rd_addr_q;
  assign acc_grant                  = grant_q;
  assign acc_refuse                 = refuse_q;
  assign op_go                      = op_go_q;
  assign op_kind                    = op_kind_q;
  assign op_addr                    = op_addr_q;
  assign op_wdata                   = op_wdata_q;
  assign read_protect_active        = ~(sys_opt_q[7:0] == RDP_OPEN);
  assign watchdog_disable_permit    = sys_opt_q[WD_OFF_BIT];
  assign deep_idle_watchdog_action  = sys_opt_q[WD_DEEP_BIT];
  assign light_idle_watchdog_action = sys_opt_q[WD_LIGHT_BIT];
  assign load_done                  = (ld_state_q == LD_DONE);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unlock_req;
    acc_valid && !pend_q && load_done && acc_kind == ACC_OPT_PROG && acc_addr == SYS_OPT_ADDR
      && acc_wdata[7:0] == RDP_OPEN && read_protect_active;
  endsequence

  sequence s_erase_then_write;
    (op_go && op_kind == ACC_MASS_ERS) ##1 (op_go && op_kind == ACC_OPT_PROG);
  endsequence

  sequence s_locked_write;
    acc_valid && !pend_q && load_done && !acc_sram && !acc_debug && !acc_boot_sram && !acc_addr[NVR_BIT]
      && (acc_kind == ACC_PROG || acc_kind == ACC_PAGE_ERS);
  endsequence

  a_unlock_erase_first: assert property (s_unlock_req |=> s_erase_then_write)
    else $error("unlock write not preceded by mass erase");
  a_fixed_pages_lock: assert property (s_locked_write and (acc_addr[PAGE_MSB:PAGE_LSB] < 8'h04)
    |=> acc_refuse && !op_go && viol_q)
    else $error("page 0 to 3 write was not refused");
  a_pair_bit_lock: assert property (s_locked_write
    and !page_pair_write_lock_bits_q[acc_addr[PAGE_MSB:PAGE_LSB+1]] |=> acc_refuse && viol_q)
    else $error("write to locked page pair passed");
  a_open_pair_grant: assert property (s_locked_write and !ctrl_q && acc_addr[PAGE_MSB:PAGE_LSB] >= 8'h04
    and page_pair_write_lock_bits_q[acc_addr[PAGE_MSB:PAGE_LSB+1]] |=> acc_grant && op_go)
    else $error("write to open page pair refused");
  a_protected_read: assert property (acc_valid && !pend_q && load_done && acc_kind == ACC_READ
    && !acc_sram && !acc_addr[NVR_BIT] && read_protect_active && !acc_from_user |=> acc_refuse && !acc_grant)
    else $error("protected read granted to foreign requester");
  a_sram_still_ok: assert property (acc_valid && !pend_q && load_done && acc_sram
    && acc_kind == ACC_READ |=> acc_grant)
    else $error("SRAM access refused under protection");
  a_debug_prog_blocked: assert property (acc_valid && !pend_q && load_done && !acc_sram
    && (acc_debug || acc_boot_sram) && acc_kind == ACC_PROG |=> acc_refuse && !op_go)
    else $error("program from debug was accepted");
  a_viol_set_wins: assert property (viol_set && viol_clr |=> viol_q)
    else $error("violation lost against clear");
  a_default_on_bad: assert property (ld_state_q == LD_WAIT && ld_idx_q == 4'h0 && fl_rd_valid
    && fl_rd_data[31:16] != ~fl_rd_data[15:0] |=> read_protect_active && watchdog_disable_permit
    && deep_idle_watchdog_action && light_idle_watchdog_action)
    else $error("bad system word did not load defaults");
  a_options_held: assert property (load_done |=> load_done && $stable(sys_opt_q)
    && $stable(page_pair_write_lock_bits_q))
    else $error("loaded options changed before reset");

endmodule

// ===== core/fop_opt_check.sv
// Option word checker: returns the low half when the high half is its complement.
// Assumes the caller supplies the default of the option being loaded.
`timescale 1ns/1ps
module fop_opt_check
  import fop_pkg::*;
(
  input  wire logic [31:0] word,
  input  wire logic [15:0] dflt,
  output logic      [15:0] value,
  output logic             valid
);

  // A torn or blank word falls back to the safe default.
  always_comb begin
    valid = (word[31:OPT_HALF] == ~word[OPT_HALF-1:0]);
    value = valid ? word[OPT_HALF-1:0] : dflt;
  end

endmodule

// ===== core/fop_page_lock.sv
// Page lock lookup: tells whether a main array page may not be programmed or erased.
// Assumes active-low lock bits, one bit for each pair of pages.
`timescale 1ns/1ps
module fop_page_lock
  import fop_pkg::*;
(
  input  wire logic [127:0] lock_bits,
  input  wire logic [7:0]   page,
  input  wire logic         lock_all,
  output logic              locked
);

  // Pair index is the page number without its lowest bit.
  always_comb begin
    locked = lock_all | (page < FIXED_LOCKED) | ~lock_bits[page[7:1]];
  end

endmodule

// ===== core/fop_pkg.sv
// Constants shared by the flash option and protection logic.
// Assumes a 32-bit APB register port and an 18-bit flash byte address space.
package fop_pkg;

  // Register offsets, byte addresses within the APB window.
  localparam logic [11:0] REG_STATUS    = 12'h000;
  localparam logic [11:0] REG_SYS_OPT   = 12'h004;
  localparam logic [11:0] REG_CTRL      = 12'h008;
  localparam logic [11:0] REG_LOCK_BASE = 12'h020;

  // Status register fields.
  localparam int ST_VIOL  = 0;
  localparam int ST_RDP   = 1;
  localparam int ST_DONE  = 2;
  localparam int ST_WD_LO = 8;

  // Control register fields and reset value.
  localparam int          CTRL_LOCK_ALL = 0;
  localparam logic        CTRL_RESET    = 1'b0;

  // Option word locations in the flash information blocks.
  localparam logic [17:0] SYS_OPT_ADDR  = 18'h201f8;
  localparam logic [17:0] LOCK_OPT_TOP  = 18'h205fc;
  localparam int          LOCK_WORDS    = 8;
  localparam logic [3:0]  LOAD_LAST_IDX = 4'h8;

  // Option word layout and defaults.
  localparam int          OPT_HALF      = 16;
  localparam int          WD_OFF_BIT    = 10;
  localparam int          WD_DEEP_BIT   = 9;
  localparam int          WD_LIGHT_BIT  = 8;
  localparam logic [7:0]  RDP_OPEN      = 8'ha5;
  localparam logic [7:0]  RDP_INV_OPEN  = 8'h5a;
  localparam logic [7:0]  RDP_DEFAULT   = 8'hff;
  localparam logic [15:0] SYS_DEFAULT   = 16'h07ff;
  localparam logic [15:0] LOCK_DEFAULT  = 16'hffff;

  // Page geometry.
  localparam int          PAGE_LSB      = 9;
  localparam int          PAGE_MSB      = 16;
  localparam int          NVR_BIT       = 17;
  localparam logic [7:0]  FIXED_LOCKED  = 8'h04;

  // Access kinds on the request port.
  localparam logic [2:0]  ACC_READ      = 3'h0;
  localparam logic [2:0]  ACC_PROG      = 3'h1;
  localparam logic [2:0]  ACC_PAGE_ERS  = 3'h2;
  localparam logic [2:0]  ACC_MASS_ERS  = 3'h3;
  localparam logic [2:0]  ACC_OPT_PROG  = 3'h4;

endpackage

// ===== testbench/fop_flash_model.sv
// Option storage model: answers each loader read with the stored 32-bit option word.
// Assumes one outstanding read at a time; answers alternate between prompt and slow.
`timescale 1ns/1ps
module fop_flash_model
  import fop_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             fl_rd_req,
  input  wire logic [17:0]      fl_rd_addr,
  input  wire logic [31:0]      sys_word,
  input  wire logic [7:0][31:0] lock_word,
  output logic                  fl_rd_valid,
  output logic      [31:0]      fl_rd_data
);
  logic [2:0] wait_cnt;
  logic       busy;
  logic       slow;

  // whole words by address
  // Data is inverted every idle cycle, so a loader that samples late gets the inverted word, which still passes the complement check.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy        <= 1'b0;
      slow        <= 1'b0;
      wait_cnt    <= 3'h0;
      fl_rd_valid <= 1'b0;
      fl_rd_data  <= 32'h0;
    end else begin
      fl_rd_valid <= 1'b0;
      fl_rd_data  <= ~fl_rd_data;
      if (fl_rd_req) begin
        busy     <= 1'b1;
        wait_cnt <= slow ? 3'h4 : 3'h0;
        slow     <= ~slow;
      end else if (busy && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (busy) begin
        busy        <= 1'b0;
        fl_rd_valid <= 1'b1;
        fl_rd_data  <= (fl_rd_addr == SYS_OPT_ADDR) ? sys_word : lock_word[3'((LOCK_OPT_TOP - fl_rd_addr) >> 2)];
      end
    end
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the flash option loader and access protection.
// Assumes the option storage model on the loader port and an APB master driven here.
`timescale 1ns/1ps
module tb
  import fop_pkg::*;
;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic      [11:0] paddr;
  logic      [31:0] pwdata, prdata, acc_wdata, op_wdata, fl_rd_data, sys_word, exp_wd;
  logic      [3:0]  pstrb, rd_idx;
  logic             fl_rd_req, fl_rd_valid, acc_valid, acc_sram, acc_from_user, acc_debug, acc_boot_sram;
  logic      [17:0] fl_rd_addr, acc_addr, op_addr, exp_ad;
  logic      [2:0]  acc_kind, op_kind;
  logic             acc_grant, acc_refuse, op_go, load_done, read_protect_active;
  logic             watchdog_disable_permit, deep_idle_watchdog_action, light_idle_watchdog_action;
  logic [7:0][31:0] lock_word, lw;
  logic      [5:0]  exp_q[$];
  logic      [5:0]  note;
  logic      [31:0] lfsr = 32'h0001_7c54;
  int               errors = 0;
  int               samples_checked = 0;
  localparam logic [3:0] W_NONE = 4'h0, W_SRAM = 4'h1, W_USR = 4'h2, W_BOOT = 4'h4, W_DBG = 4'h8;
  localparam logic [5:0] REF = 6'h10, GNT = 6'h20;

  fop_ctrl i_fop_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fl_rd_req(fl_rd_req), .fl_rd_addr(fl_rd_addr), .fl_rd_valid(fl_rd_valid), .fl_rd_data(fl_rd_data),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_sram(acc_sram), .acc_from_user(acc_from_user), .acc_debug(acc_debug),
    .acc_boot_sram(acc_boot_sram), .acc_grant(acc_grant), .acc_refuse(acc_refuse), .op_go(op_go),
    .op_kind(op_kind), .op_addr(op_addr), .op_wdata(op_wdata), .read_protect_active(read_protect_active),
    .watchdog_disable_permit(watchdog_disable_permit), .deep_idle_watchdog_action(deep_idle_watchdog_action),
    .light_idle_watchdog_action(light_idle_watchdog_action), .load_done(load_done));

  fop_flash_model i_fop_flash_model (.pclk(pclk), .presetn(presetn), .fl_rd_req(fl_rd_req),
    .fl_rd_addr(fl_rd_addr), .sys_word(sys_word), .lock_word(lock_word), .fl_rd_valid(fl_rd_valid),
    .fl_rd_data(fl_rd_data));

  // Free-running 25 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Pseudo-random data for write payloads; a fixed start keeps runs repeatable.
  function automatic logic [31:0] lfsr_next();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [17:0] pg(input logic [7:0] p);
    return {1'b0, p, 9'h0};
  endfunction

  function automatic logic [5:0] gok(input logic [2:0] k);
    return {3'b101, k};
  endfunction

  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the edge that samples pready.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [32:0] expv);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 36'(pready), 36'h1);
    if (!wr) chk("apb_read", 36'({pslverr, prdata}), 36'(expv));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One access request; the expected answer is noted for the monitor.
  task automatic acc(input logic [2:0] kind, input logic [17:0] addr, input logic [3:0] who, input logic [5:0] e);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_kind  <= kind;
    acc_addr  <= addr;
    exp_ad    = addr;
    exp_wd    = (kind == ACC_OPT_PROG) ? 32'hff5a_00a5 : lfsr_next();
    acc_wdata <= exp_wd;
    {acc_debug, acc_boot_sram, acc_from_user, acc_sram} <= who;
    exp_q.push_back(e);
    @(posedge pclk);
    acc_valid <= 1'b0;
  endtask

  task automatic boot(input logic [31:0] sw, input logic [7:0][31:0] lws);
    int n;
    sys_word  = sw;
    lock_word = lws;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("load_done", 36'(load_done), 36'h1);
  endtask

  task automatic levels(input logic [3:0] e);
    chk("levels", 36'({read_protect_active, watchdog_disable_permit, deep_idle_watchdog_action,
        light_idle_watchdog_action}), 36'(e));
  endtask

  // Every answer or array operation takes the oldest note off the queue.
  always @(posedge pclk) begin
    #1;
    if (presetn && (acc_grant || acc_refuse || op_go)) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3f;
      chk("acc_answer", 36'({acc_grant, acc_refuse, op_go, op_go ? op_kind : 3'h0}), 36'(note));
      // An array operation must carry the address and data of the request behind it.
      if (op_go) begin
        chk("op_addr", 36'(op_addr), 36'(exp_ad));
        chk("op_wdata", 36'(op_wdata), 36'(exp_wd));
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx <= 4'h0;
    end else if (fl_rd_req) begin
      chk("fl_rd_addr", 36'(fl_rd_addr), (rd_idx == 4'h0) ? 36'(SYS_OPT_ADDR) :
          36'(LOCK_OPT_TOP) + 36'h4 - 36'(rd_idx) * 36'h4);
      rd_idx <= rd_idx + 4'h1;
    end
  end

  // A hang ends the run through the same closing task.
  initial begin
    #(40 * 20000);
    errors++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, acc_valid, acc_sram, acc_from_user, acc_debug, acc_boot_sram} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    acc_kind = '0;
    acc_addr = '0;
    acc_wdata = '0;
    // Broken system word, pages 10-11 and 32-33 locked, broken top word that would lock all.
    lw = {8{32'h0000_ffff}};
    lw[0] = 32'h0020_ffdf;
    lw[1] = 32'h0001_fffe;
    lw[7] = 32'h0000_0000;
    boot(32'h0000_00ff, lw);
    levels(4'hf);
    acc(ACC_PROG, pg(8'd10), W_USR, REF);
    acc(ACC_PROG, pg(8'd12), W_USR, gok(ACC_PROG));
    acc(ACC_PAGE_ERS, pg(8'd11), W_USR, REF);
    acc(ACC_PROG, pg(8'd3), W_USR, REF);
    acc(ACC_PAGE_ERS, pg(8'd4), W_USR, gok(ACC_PAGE_ERS));
    acc(ACC_PROG, pg(8'd32), W_USR, REF);
    acc(ACC_PROG, pg(8'd254), W_USR, gok(ACC_PROG));
    acc(ACC_PROG, pg(8'd12), W_DBG, REF);
    acc(ACC_PAGE_ERS, pg(8'd12), W_BOOT, REF);
    acc(ACC_MASS_ERS, pg(8'd0), W_DBG, gok(ACC_MASS_ERS));
    acc(ACC_READ, pg(8'd20), W_NONE, REF);
    acc(ACC_READ, pg(8'd20), W_USR, GNT);
    acc(ACC_READ, pg(8'd20), W_DBG | W_SRAM, GNT);
    acc(ACC_PROG, pg(8'd20), W_DBG | W_SRAM, GNT);
    acc(ACC_READ, SYS_OPT_ADDR, W_NONE, GNT);
    apb(1'b0, REG_STATUS, 32'h0, 33'h0_0000_0707);
    apb(1'b1, REG_STATUS, 32'h1, 33'h0);
    apb(1'b0, REG_STATUS, 32'h0, 33'h0_0000_0706);
    apb(1'b1, REG_SYS_OPT, lfsr_next(), 33'h0);
    apb(1'b0, REG_SYS_OPT, 32'h0, 33'h0_0000_07ff);
    apb(1'b0, REG_LOCK_BASE, 32'h0, 33'h0_0000_ffdf);
    apb(1'b0, REG_LOCK_BASE + 12'h004, 32'h0, 33'h0_0000_fffe);
    apb(1'b0, REG_LOCK_BASE + 12'h01c, 32'h0, 33'h0_0000_ffff);
    apb(1'b0, 12'h100, 32'h0, 33'h1_0000_0000);
    // Unlocking code: mass erase first, then the option word itself.
    // The option write comes a cycle after the erase, so its note queues behind the erase note.
    acc(ACC_OPT_PROG, SYS_OPT_ADDR, W_USR, gok(ACC_MASS_ERS));
    exp_q.push_back(gok(ACC_OPT_PROG) & 6'h0f);
    repeat (3) @(posedge pclk);
    levels(4'hf);
    // Second load: open code, watchdog bits clear, erased lock words fall back to unlocked.
    boot(32'hff5a_00a5, {8{32'hffff_ffff}});
    levels(4'h0);
    apb(1'b0, REG_STATUS, 32'h0, 33'h0_0000_0004);
    acc(ACC_READ, pg(8'd20), W_NONE, GNT);
    acc(ACC_PROG, pg(8'd10), W_USR, gok(ACC_PROG));
    acc(ACC_OPT_PROG, SYS_OPT_ADDR, W_USR, gok(ACC_OPT_PROG));
    acc(3'h7, pg(8'd12), W_USR, REF);
    acc(ACC_PROG, pg(8'd2), W_USR, REF);
    // Clear and a new violation land on the same edge; the new violation must survive.
    fork
      apb(1'b1, REG_STATUS, 32'h1, 33'h0);
      begin
        @(posedge pclk);
        acc(ACC_PROG, pg(8'd3), W_USR, REF);
      end
    join
    apb(1'b0, REG_STATUS, 32'h0, 33'h0_0000_0005);
    apb(1'b1, REG_CTRL, 32'h1, 33'h0);
    apb(1'b0, REG_CTRL, 32'h0, 33'h0_0000_0001);
    acc(ACC_PROG, pg(8'd12), W_USR, REF);
    repeat (3) @(posedge pclk);
    chk("queue_left", 36'(exp_q.size()), 36'h0);
    summarize();
  end
endmodule
